// file: logic/spc_access_check.v
// System register access privilege checker, top level
`timescale 1ns/1ps
`include "spc_defs.vh"

// Functional notes
// - Conventional: protected need supervisor; timestamp reads user.
// - Virtualized: snooze, bank, timestamp ctrl, perfmon need hypervisor.
// - Virtualized: protection ID writes need hypervisor, reads supervisor.
// - Timestamp halves always readable by user; write level follows mode.
// - Selections 12 and 13 follow the rule, except two config registers.
// - User perfmon setting lowers perfmon register access to user.
// - Virtualized: guest perfmon setting lowers perfmon to supervisor.
// - One shared copy of protected registers, never switched by mode.
// - Guest supervisor level alone cannot reach hypervisor-raised registers.
// - Virtualized: visible register model follows host or guest mode.
// - Multiplexed registers route to the copy of the current mode.
// - In guest mode host context copies are unreachable by moves.

module spc_access_check (
	// Clock and reset
	input wire clk,
	input wire reset_n,
	// Mode from the pipeline
	input wire virt_mode,
	input wire guest_mode,
	input wire [1:0] cur_priv,
	// Register move request
	input wire req_valid,
	input wire req_write,
	input wire [4:0] req_reg_id,
	input wire [4:0] req_sel_id,
	input wire [7:0] req_wdata,
	// Check result
	output reg resp_valid,
	output reg resp_grant,
	output reg resp_priv_fault,
	output reg [1:0] resp_req_priv,
	output reg resp_protected,
	output reg resp_muxed,
	output reg resp_guest_copy,
	output reg [4:0] resp_reg_id,
	output reg [4:0] resp_sel_id,
	output reg resp_write_en,
	output reg resp_read_en,
	output reg [2:0] reg_model,
	// Software register port
	input wire [7:0] bus_addr,
	input wire [31:0] bus_wdata,
	input wire bus_write,
	input wire bus_read,
	output reg [31:0] bus_rdata
);

	// ------------------------------------------------------------------
	// Access settings and status
	// ------------------------------------------------------------------
	reg [7:0] user_pm;
	reg [7:0] guest_pm;
	reg [15:0] fault_count;
	reg [10:0] last_fault;
	reg last_fault_seen;

	wire lk_protected;
	wire [1:0] lk_priv;

	// Single shared lookup; protected registers have one copy only
	spc_priv_lookup u_lookup (
		.reg_id(req_reg_id),
		.sel_id(req_sel_id),
		.is_write(req_write),
		.virt_mode(virt_mode),
		.user_pm(user_pm),
		.guest_pm(guest_pm),
		.protected_hit(lk_protected),
		.req_priv(lk_priv)
	);

	// ------------------------------------------------------------------
	// Multiplexed register decode
	// ------------------------------------------------------------------
	// Original numbers of the host/guest pairs
	function is_orig;
		input [4:0] sel;
		input [4:0] rid;
		begin
			case (sel)
			`SPC_SEL_BASIC0:
				is_orig = (rid == 5'h00) || (rid == 5'h01) ||
					(rid == 5'h02) || (rid == 5'h03) ||
					(rid == 5'h05) || (rid == 5'h0D) ||
					(rid == 5'h0E) || (rid == 5'h1C) ||
					(rid == 5'h1D);
			`SPC_SEL_BASIC1:
				is_orig = (rid == 5'h00) || (rid == 5'h01) ||
					(rid == 5'h03) || (rid == 5'h04) ||
					(rid == 5'h08);
			`SPC_SEL_BASIC2:
				is_orig = (rid == 5'h00) || (rid == 5'h06) ||
					(rid == 5'h08) || (rid == 5'h0D) ||
					(rid == 5'h0E);
			`SPC_SEL_MEMPROT:
				is_orig = (rid == 5'h00);
			default:
				is_orig = 1'b0;
			endcase
		end
	endfunction

	// Guest-copy alias numbers, usable from host mode
	function is_alias;
		input [4:0] sel;
		input [4:0] rid;
		begin
			if (sel != `SPC_SEL_GUEST_CTX)
				is_alias = 1'b0;
			else
				case (rid)
				5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h06, 5'h08,
				5'h0D, 5'h0E, 5'h10, 5'h11, 5'h13, 5'h14, 5'h15,
				5'h16, 5'h18, 5'h19, 5'h1C, 5'h1D, 5'h1E:
					is_alias = 1'b1;
				default:
					is_alias = 1'b0;
				endcase
		end
	endfunction

	// ------------------------------------------------------------------
	// Combined decision
	// ------------------------------------------------------------------
	wire hit_orig;
	wire hit_alias;
	wire host_blocked;
	wire priv_ok;
	wire grant;
	wire in_guest;
	wire gpm_sysreg_wr;
	reg [2:0] next_model;

	assign in_guest = virt_mode && guest_mode;
	assign hit_orig = is_orig(req_sel_id, req_reg_id);
	assign hit_alias = is_alias(req_sel_id, req_reg_id);
	// Alias numbers reach the other context; from a guest that is host
	assign host_blocked = in_guest && hit_alias;
	// Guest code may hold supervisor level, so the plain compare is
	// enough to keep it out of hypervisor-raised registers
	assign priv_ok = (cur_priv >= lk_priv);
	assign grant = priv_ok && !host_blocked;
	// A granted move to the guest perfmon setting updates our copy
	assign gpm_sysreg_wr = req_valid && req_write && grant &&
		(req_sel_id == `SPC_SEL_COUNTER) &&
		(req_reg_id == `SPC_REG_GUEST_PM_CTRL);

	// The model tracks the modes one cycle late, like the check result
	always @* begin
		next_model = `SPC_MODEL_CONV;
		if (virt_mode) begin
			if (guest_mode)
				next_model = `SPC_MODEL_GUEST;
			else
				next_model = `SPC_MODEL_HOST;
		end
	end

	// ------------------------------------------------------------------
	// Routing of multiplexed registers
	// ------------------------------------------------------------------
	wire alias_from_host;
	wire next_guest_copy;
	wire [4:0] next_reg_id;
	wire [4:0] next_sel_id;

	// Original number goes to the current mode's copy; an alias used
	// from host reaches the guest copy under its original number
	assign alias_from_host = hit_alias && !in_guest;
	assign next_guest_copy = (hit_orig && in_guest) || alias_from_host;
	assign next_reg_id = alias_from_host ?
		alias_to_orig_reg(req_reg_id) : req_reg_id;
	assign next_sel_id = alias_from_host ?
		alias_to_orig_sel(req_reg_id) : req_sel_id;

	// ------------------------------------------------------------------
	// Response pipeline stage
	// ------------------------------------------------------------------
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			resp_valid <= 1'b0;
			resp_grant <= 1'b0;
			resp_priv_fault <= 1'b0;
			resp_req_priv <= `SPC_PRIV_USER;
			resp_protected <= 1'b0;
			resp_muxed <= 1'b0;
			resp_guest_copy <= 1'b0;
			resp_reg_id <= 5'h00;
			resp_sel_id <= 5'h00;
			resp_write_en <= 1'b0;
			resp_read_en <= 1'b0;
			reg_model <= `SPC_MODEL_CONV;
		end else begin
			reg_model <= next_model;
			resp_valid <= req_valid;
			resp_grant <= req_valid && grant;
			resp_priv_fault <= req_valid && !grant;
			resp_req_priv <= lk_priv;
			resp_protected <= lk_protected;
			resp_muxed <= hit_orig || hit_alias;
			resp_guest_copy <= next_guest_copy;
			resp_reg_id <= next_reg_id;
			resp_sel_id <= next_sel_id;
			resp_write_en <= req_valid && req_write && grant;
			resp_read_en <= req_valid && !req_write && grant;
		end
	end

	// Alias register number back to the original register number
	function [4:0] alias_to_orig_reg;
		input [4:0] rid;
		begin
			case (rid)
			5'h10, 5'h1E, 5'h19: alias_to_orig_reg = 5'h00;
			5'h11: alias_to_orig_reg = 5'h01;
			5'h13: alias_to_orig_reg = 5'h03;
			5'h14: alias_to_orig_reg = 5'h04;
			5'h18: alias_to_orig_reg = 5'h08;
			5'h15: alias_to_orig_reg = 5'h0D;
			5'h16: alias_to_orig_reg = 5'h0E;
			default: alias_to_orig_reg = rid;
			endcase
		end
	endfunction

	// Alias register number to the original selection ID
	function [4:0] alias_to_orig_sel;
		input [4:0] rid;
		begin
			case (rid)
			5'h10, 5'h11, 5'h13, 5'h14, 5'h18:
				alias_to_orig_sel = `SPC_SEL_BASIC1;
			5'h1E, 5'h06, 5'h08, 5'h15, 5'h16:
				alias_to_orig_sel = `SPC_SEL_BASIC2;
			5'h19:
				alias_to_orig_sel = `SPC_SEL_MEMPROT;
			default:
				alias_to_orig_sel = `SPC_SEL_BASIC0;
			endcase
		end
	endfunction

	// ------------------------------------------------------------------
	// Access settings
	// ------------------------------------------------------------------
	wire wr_user_pm;
	wire wr_guest_pm;

	assign wr_user_pm = bus_write && bus_addr == `SPC_ADDR_USER_PM;
	assign wr_guest_pm = bus_write && bus_addr == `SPC_ADDR_GUEST_PM;

	// A move from the pipeline wins over a port write in the same cycle;
	// both reach the one shared copy
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			user_pm <= `SPC_RST_PM_CTRL;
			guest_pm <= `SPC_RST_PM_CTRL;
		end else begin
			if (wr_user_pm)
				user_pm <= bus_wdata[7:0];
			if (gpm_sysreg_wr)
				guest_pm <= req_wdata;
			else if (wr_guest_pm)
				guest_pm <= bus_wdata[7:0];
		end
	end

	// ------------------------------------------------------------------
	// Fault tracking
	// ------------------------------------------------------------------
	wire fault_now;
	wire count_clear;
	wire seen_clear;
	wire [15:0] next_fault_count;
	wire [10:0] next_last_fault;

	assign fault_now = req_valid && !grant;
	assign count_clear = bus_write && bus_addr == `SPC_ADDR_FAULT_COUNT;
	assign seen_clear = bus_write && bus_addr == `SPC_ADDR_LAST_FAULT;
	// Direction, selection and number are enough to name the move
	assign next_last_fault = {req_write, req_sel_id, req_reg_id};
	// A fault in the clearing cycle is counted, not lost; counter
	// saturates so a storm of faults cannot wrap to a small value
	assign next_fault_count = count_clear ?
		{15'h0000, fault_now} :
		((fault_now && fault_count != 16'hFFFF) ?
		fault_count + 16'h0001 : fault_count);

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			fault_count <= `SPC_RST_COUNT;
			last_fault <= 11'h000;
			last_fault_seen <= 1'b0;
		end else begin
			fault_count <= next_fault_count;
			if (fault_now) begin
				last_fault <= next_last_fault;
				last_fault_seen <= 1'b1;
			end else if (seen_clear) begin
				last_fault_seen <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// Software read port
	// ------------------------------------------------------------------
	reg [31:0] next_rdata;

	always @* begin
		next_rdata = 32'h00000000;
		case (bus_addr)
		`SPC_ADDR_USER_PM:
			next_rdata = {24'h000000, user_pm};
		`SPC_ADDR_GUEST_PM:
			next_rdata = {24'h000000, guest_pm};
		`SPC_ADDR_STATUS:
			next_rdata = {26'h0000000, last_fault_seen, reg_model,
				resp_req_priv};
		`SPC_ADDR_FAULT_COUNT:
			next_rdata = {16'h0000, fault_count};
		`SPC_ADDR_LAST_FAULT:
			next_rdata = {20'h00000, last_fault_seen, last_fault};
		default:
			next_rdata = 32'h00000000;
		endcase
	end

	// Read data stand for one cycle only, zero otherwise
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			bus_rdata <= 32'h00000000;
		else if (bus_read)
			bus_rdata <= next_rdata;
		else
			bus_rdata <= 32'h00000000;
	end

endmodule // spc_access_check

// file: logic/spc_defs.vh
// Constants for the system register access privilege checker
`ifndef SPC_DEFS_VH
`define SPC_DEFS_VH

// ----------------------------------------------------------------------
// Privilege levels, ordered user < supervisor < hypervisor
// ----------------------------------------------------------------------
`define SPC_PRIV_USER 2'h0
`define SPC_PRIV_SUPER 2'h1
`define SPC_PRIV_HYPER 2'h2

// ----------------------------------------------------------------------
// Selection IDs
// ----------------------------------------------------------------------
`define SPC_SEL_BASIC0 5'h00
`define SPC_SEL_BASIC1 5'h01
`define SPC_SEL_BASIC2 5'h02
`define SPC_SEL_MEMPROT 5'h05
`define SPC_SEL_GUEST_CTX 5'h09
`define SPC_SEL_COUNTER 5'h0B
`define SPC_SEL_HWSPEC_A 5'h0C
`define SPC_SEL_HWSPEC_B 5'h0D
`define SPC_SEL_PM_MAIN 5'h0E
`define SPC_SEL_PM_SUB 5'h0F

// ----------------------------------------------------------------------
// Register numbers of the protected registers and of the two unprotected config registers
// ----------------------------------------------------------------------
`define SPC_REG_SNOOZE_CFG 5'h15
`define SPC_REG_PROT_BANK 5'h11
`define SPC_REG_PROT_ID_BASE 5'h18
`define SPC_REG_TS_LOW 5'h00
`define SPC_REG_TS_HIGH 5'h01
`define SPC_REG_TS_CTRL 5'h02
`define SPC_REG_GUEST_PM_CTRL 5'h09
`define SPC_REG_PM_COUNT_BASE 5'h10
`define SPC_REG_LOAD_STORE_CFG 5'h02
`define SPC_REG_CACHE_CFG 5'h0C

// ----------------------------------------------------------------------
// Register model codes, one-hot
// ----------------------------------------------------------------------
`define SPC_MODEL_CONV 3'h1
`define SPC_MODEL_HOST 3'h2
`define SPC_MODEL_GUEST 3'h4

// ----------------------------------------------------------------------
// Software register port offsets and reset values
// ----------------------------------------------------------------------
`define SPC_ADDR_USER_PM 8'h00
`define SPC_ADDR_GUEST_PM 8'h04
`define SPC_ADDR_STATUS 8'h08
`define SPC_ADDR_FAULT_COUNT 8'h0C
`define SPC_ADDR_LAST_FAULT 8'h10
`define SPC_RST_PM_CTRL 8'h00
`define SPC_RST_COUNT 16'h0000

`endif

// file: logic/spc_priv_lookup.v
// Required-privilege lookup for one system register access
`timescale 1ns/1ps
`include "spc_defs.vh"

module spc_priv_lookup (
	// Access
	input wire [4:0] reg_id,
	input wire [4:0] sel_id,
	input wire is_write,
	input wire virt_mode,
	// Performance-monitor access settings, one bit per counter
	input wire [7:0] user_pm,
	input wire [7:0] guest_pm,
	// Result
	output reg protected_hit,
	output reg [1:0] req_priv
);

	// Raised level: supervisor normally, hypervisor when virtualized
	wire [1:0] raised;
	wire pm_hit;
	wire [2:0] pm_idx;

	assign raised = virt_mode ? `SPC_PRIV_HYPER : `SPC_PRIV_SUPER;
	assign pm_idx = reg_id[2:0];
	assign pm_hit = ((sel_id == `SPC_SEL_PM_MAIN) &&
		((reg_id[4:3] == 2'h0) || (reg_id[4:3] == 2'h2))) ||
		((sel_id == `SPC_SEL_PM_SUB) && (reg_id[4:3] == 2'h0));

	always @* begin
		protected_hit = 1'b1;
		req_priv = raised;
		if (pm_hit) begin
			// User override beats the guest one: it is the lower level
			if (user_pm[pm_idx])
				req_priv = `SPC_PRIV_USER;
			else if (virt_mode && guest_pm[pm_idx])
				req_priv = `SPC_PRIV_SUPER;
		end else if (sel_id == `SPC_SEL_MEMPROT &&
			reg_id[4:3] == 2'h3) begin
			if (!is_write)
				req_priv = `SPC_PRIV_SUPER;
		end else if (sel_id == `SPC_SEL_COUNTER &&
			(reg_id == `SPC_REG_TS_LOW || reg_id == `SPC_REG_TS_HIGH)) begin
			if (!is_write)
				req_priv = `SPC_PRIV_USER;
		end else if (sel_id == `SPC_SEL_HWSPEC_A) begin
			protected_hit = (reg_id != `SPC_REG_LOAD_STORE_CFG);
		end else if (sel_id == `SPC_SEL_HWSPEC_B) begin
			protected_hit = (reg_id != `SPC_REG_CACHE_CFG);
		end else if (!((sel_id == `SPC_SEL_BASIC0 &&
			reg_id == `SPC_REG_SNOOZE_CFG) ||
			(sel_id == `SPC_SEL_MEMPROT && reg_id == `SPC_REG_PROT_BANK) ||
			(sel_id == `SPC_SEL_COUNTER &&
			(reg_id == `SPC_REG_TS_CTRL ||
			reg_id == `SPC_REG_GUEST_PM_CTRL)))) begin
			protected_hit = 1'b0;
		end
		if (!protected_hit)
			req_priv = `SPC_PRIV_USER;
	end

endmodule // spc_priv_lookup

// file: dv/spc_pipe_model.sv
// CPU pipeline model that issues register moves to the checker
`timescale 1ns/1ps
module spc_pipe_model (
	// Clock
	input wire clk,
	// Mode and register move request
	output reg virt_mode,
	output reg guest_mode,
	output reg [1:0] cur_priv,
	output reg req_valid,
	output reg req_write,
	output reg [4:0] req_reg_id,
	output reg [4:0] req_sel_id,
	output reg [7:0] req_wdata
);
	initial begin
		{virt_mode, guest_mode, cur_priv, req_valid, req_write} = 6'h00;
		{req_reg_id, req_sel_id, req_wdata} = 18'h00000;
	end

	// One move, one-cycle request; the qualifiers are scrambled
	// afterwards so the checker cannot lean on stale values
	task issue(input v, g, input [1:0] p, input w, input [4:0] rid,
		input [4:0] sel, input [7:0] wd);
	begin
		@(posedge clk);
		virt_mode <= v;
		guest_mode <= g;
		cur_priv <= p;
		req_valid <= 1'b1;
		req_write <= w;
		req_reg_id <= rid;
		req_sel_id <= sel;
		req_wdata <= wd;
		@(posedge clk);
		req_valid <= 1'b0;
		req_write <= !w;
		req_reg_id <= ~rid;
		req_sel_id <= ~sel;
		req_wdata <= ~wd;
	end
	endtask
endmodule // spc_pipe_model

// file: dv/spc_access_check_properties.sv
// Concurrent checks on the ports of the access privilege checker
`timescale 1ns/1ps
module spc_access_check_props (
	// Clock and reset
	input wire clk,
	input wire reset_n,
	// Mode and request
	input wire virt_mode,
	input wire guest_mode,
	input wire [1:0] cur_priv,
	input wire req_valid,
	input wire req_write,
	input wire [4:0] req_reg_id,
	input wire [4:0] req_sel_id,
	// Result
	input wire resp_valid,
	input wire resp_grant,
	input wire resp_priv_fault,
	input wire [1:0] resp_req_priv,
	input wire resp_protected,
	input wire resp_write_en,
	input wire resp_read_en,
	input wire [2:0] reg_model
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	AST_RESP_NEXT:
	assert property (req_valid |=> resp_valid)
		else $error("no response after a move");
	AST_NO_SPURIOUS:
	assert property (!req_valid |=> !resp_valid && !resp_write_en
		&& !resp_read_en) else $error("response without a move");
	AST_LEVEL_ORDER:
	assert property (req_valid && !(virt_mode && guest_mode
		&& req_sel_id == 5'h09) |=> resp_grant ==
		($past(cur_priv) >= resp_req_priv)) else $error("grant vs level");
	AST_HOST_CTX_BLOCKED:
	assert property (req_valid && virt_mode && guest_mode
		&& req_sel_id == 5'h09 && req_reg_id == 5'h05 |=> resp_priv_fault)
		else $error("host context reached from guest");
	AST_FAULT_NO_COMMIT:
	assert property (resp_priv_fault |-> !resp_write_en && !resp_read_en
		&& !resp_grant) else $error("faulted move committed");
	AST_COMMIT_KIND:
	assert property (req_valid && req_write |=> !resp_read_en
		&& resp_write_en == resp_grant) else $error("wrong commit kind");
	AST_TS_READ_USER:
	assert property (req_valid && !req_write && req_sel_id == 5'h0B
		&& req_reg_id < 5'h02 |=> resp_req_priv == 2'h0)
		else $error("timestamp read not at user level");
	AST_PROT_ID_WR:
	assert property (req_valid && virt_mode && req_write
		&& req_sel_id == 5'h05 && req_reg_id[4:3] == 2'h3
		|=> resp_req_priv == 2'h2) else $error("protection id write level");
	AST_GUEST_SV_DENIED:
	assert property (req_valid && virt_mode && cur_priv == 2'h1
		&& req_sel_id == 5'h00 && req_reg_id == 5'h15 |=> resp_priv_fault)
		else $error("supervisor reached raised register");
	AST_CONV_SV:
	assert property (req_valid && !virt_mode && req_sel_id == 5'h05
		&& req_reg_id == 5'h11 |=> resp_req_priv == 2'h1)
		else $error("conventional level not supervisor");
	AST_MODEL_GUEST:
	assert property (virt_mode && guest_mode |=> reg_model == 3'h4)
		else $error("guest model not shown");
	AST_CACHE_EXCL:
	assert property (req_valid && req_sel_id == 5'h0D
		&& req_reg_id == 5'h0C |=> !resp_protected)
		else $error("cache config treated as protected");
endmodule // spc_access_check_props

bind spc_access_check spc_access_check_props u_props (.clk, .reset_n,
	.virt_mode, .guest_mode, .cur_priv, .req_valid, .req_write,
	.req_reg_id, .req_sel_id, .resp_valid, .resp_grant, .resp_priv_fault,
	.resp_req_priv, .resp_protected, .resp_write_en, .resp_read_en,
	.reg_model);

// file: dv/test_spc_access_check.sv
// Self-checking testbench for the access privilege checker
`timescale 1ns/1ps
module test_spc_access_check;
	reg clk, reset_n, bus_write, bus_read;
	reg [7:0] bus_addr;
	reg [31:0] bus_wdata;
	wire virt_mode, guest_mode, req_valid, req_write;
	wire [1:0] cur_priv, resp_req_priv;
	wire [4:0] req_reg_id, req_sel_id, resp_reg_id, resp_sel_id;
	wire [7:0] req_wdata;
	wire resp_valid, resp_grant, resp_priv_fault, resp_protected;
	wire resp_muxed, resp_guest_copy, resp_write_en, resp_read_en;
	wire [2:0] reg_model;
	wire [31:0] bus_rdata;
	integer n_fail, num_checks, n_flt;

	spc_pipe_model pipe (.clk, .virt_mode, .guest_mode, .cur_priv,
		.req_valid, .req_write, .req_reg_id, .req_sel_id, .req_wdata);
	spc_access_check uut (.clk, .reset_n, .virt_mode, .guest_mode,
		.cur_priv, .req_valid, .req_write, .req_reg_id, .req_sel_id,
		.req_wdata, .resp_valid, .resp_grant, .resp_priv_fault,
		.resp_req_priv, .resp_protected, .resp_muxed, .resp_guest_copy,
		.resp_reg_id, .resp_sel_id, .resp_write_en, .resp_read_en,
		.reg_model, .bus_addr, .bus_wdata, .bus_write, .bus_read,
		.bus_rdata);

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task check(input [31:0] seen, input [31:0] exp);
	begin
		num_checks = num_checks + 1;
		if (seen !== exp) begin
			n_fail = n_fail + 1;
			$display("unexpected at %0t: seen %h expected %h", $time, seen,
				exp);
		end
	end
	endtask

	task tally_and_finish;
	begin
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	end
	endtask

	task bus_wr(input [7:0] a, input [31:0] d);
	begin
		@(posedge clk);
		bus_write <= 1'b1;
		bus_addr <= a;
		bus_wdata <= d;
		@(posedge clk);
		bus_write <= 1'b0;
		bus_wdata <= ~d;
	end
	endtask

	task bus_rd(input [7:0] a, input [31:0] exp);
	begin
		@(posedge clk);
		bus_read <= 1'b1;
		bus_addr <= a;
		@(posedge clk);
		bus_read <= 1'b0;
		#1;
		check(bus_rdata, exp);
	end
	endtask

	// One move and its verdict; level 3 means the level is not judged
	task acc(input v, g, input [1:0] p, input w, input [4:0] rid,
		input [4:0] sel, input eg, input [1:0] ep);
	begin
		pipe.issue(v, g, p, w, rid, sel, 8'h00);
		#1;
		check(resp_valid, 1'b1);
		check(resp_grant, eg);
		check(resp_priv_fault, !eg);
		if (ep != 2'h3)
			check(resp_req_priv, ep);
		check(resp_write_en, eg & w);
		check(resp_read_en, eg & !w);
		if (!eg)
			n_flt = n_flt + 1;
	end
	endtask

	task t_reset;
	begin
		check(reg_model, 3'h1);
		check(resp_valid, 1'b0);
		bus_rd(8'h00, 32'h0);
		bus_rd(8'h04, 32'h0);
		bus_rd(8'h0C, 32'h0);
		$display("reset test done");
	end
	endtask

	task t_conv;
	begin
		acc(0, 0, 2'h1, 1, 5'h15, 5'h00, 1, 2'h1);
		acc(0, 0, 2'h0, 0, 5'h15, 5'h00, 0, 2'h1);
		acc(0, 0, 2'h0, 0, 5'h00, 5'h0B, 1, 2'h0);
		acc(0, 0, 2'h0, 1, 5'h01, 5'h0B, 0, 2'h1);
		acc(0, 0, 2'h1, 1, 5'h18, 5'h05, 1, 2'h1);
		acc(0, 0, 2'h1, 0, 5'h11, 5'h05, 1, 2'h1);
		acc(0, 0, 2'h0, 1, 5'h05, 5'h0C, 0, 2'h1);
		$display("conventional test done");
	end
	endtask

	task t_virt;
	begin
		acc(1, 0, 2'h1, 1, 5'h15, 5'h00, 0, 2'h2);
		acc(1, 0, 2'h2, 0, 5'h11, 5'h05, 1, 2'h2);
		acc(1, 0, 2'h1, 1, 5'h1F, 5'h05, 0, 2'h2);
		acc(1, 0, 2'h1, 0, 5'h1F, 5'h05, 1, 2'h1);
		acc(1, 0, 2'h0, 0, 5'h01, 5'h0B, 1, 2'h0);
		acc(1, 0, 2'h1, 1, 5'h00, 5'h0B, 0, 2'h2);
		acc(1, 0, 2'h1, 1, 5'h02, 5'h0B, 0, 2'h2);
		acc(1, 0, 2'h1, 1, 5'h09, 5'h0B, 0, 2'h2);
		acc(1, 0, 2'h1, 1, 5'h05, 5'h0C, 0, 2'h2);
		acc(1, 0, 2'h0, 1, 5'h02, 5'h0C, 1, 2'h0);
		check(resp_protected, 1'b0);
		acc(1, 0, 2'h0, 1, 5'h0C, 5'h0D, 1, 2'h0);
		$display("virtualization test done");
	end
	endtask

	task t_pm;
	begin
		acc(1, 0, 2'h1, 1, 5'h00, 5'h0E, 0, 2'h2);
		bus_wr(8'h04, 32'h1);
		acc(1, 0, 2'h1, 1, 5'h00, 5'h0E, 1, 2'h1);
		acc(1, 0, 2'h1, 0, 5'h01, 5'h0E, 0, 2'h2);
		acc(0, 0, 2'h0, 0, 5'h00, 5'h0E, 0, 2'h1);
		bus_wr(8'h00, 32'h2);
		acc(1, 0, 2'h0, 0, 5'h01, 5'h0F, 1, 2'h0);
		acc(1, 0, 2'h0, 1, 5'h11, 5'h0E, 1, 2'h0);
		acc(0, 0, 2'h0, 0, 5'h01, 5'h0E, 1, 2'h0);
		bus_rd(8'h00, 32'h2);
		bus_rd(8'h04, 32'h1);
		pipe.issue(1, 0, 2'h2, 1, 5'h09, 5'h0B, 8'h5A);
		#1;
		check(resp_write_en, 1'b1);
		bus_rd(8'h04, 32'h5A);
		pipe.issue(1, 0, 2'h1, 1, 5'h09, 5'h0B, 8'hFF);
		#1;
		check(resp_priv_fault, 1'b1);
		n_flt = n_flt + 1;
		bus_rd(8'h04, 32'h5A);
		$display("perfmon test done");
	end
	endtask

	task t_model;
	begin
		acc(1, 1, 2'h1, 0, 5'h05, 5'h00, 1, 2'h0);
		check(reg_model, 3'h4);
		check({resp_muxed, resp_guest_copy}, 2'h3);
		acc(1, 1, 2'h2, 0, 5'h05, 5'h09, 0, 2'h3);
		acc(1, 0, 2'h2, 0, 5'h05, 5'h09, 1, 2'h3);
		check(reg_model, 3'h2);
		check({resp_guest_copy, resp_sel_id, resp_reg_id}, 11'h405);
		acc(1, 1, 2'h2, 1, 5'h15, 5'h00, 1, 2'h2);
		check({resp_muxed, resp_guest_copy}, 2'h0);
		acc(0, 1, 2'h1, 0, 5'h05, 5'h00, 1, 2'h0);
		check({reg_model, resp_guest_copy}, 4'h2);
		$display("register model test done");
	end
	endtask

	task t_count;
	begin
		bus_rd(8'h08, 32'h24);
		bus_rd(8'h10, 32'h925);
		bus_rd(8'h0C, n_flt);
		bus_wr(8'h0C, 32'h0);
		bus_rd(8'h0C, 32'h0);
		bus_wr(8'h10, 32'h0);
		bus_rd(8'h10, 32'h125);
		bus_wr(8'h20, 32'hFF);
		bus_rd(8'h20, 32'h0);
		$display("fault count test done");
	end
	endtask

	initial begin
		n_fail = 0;
		num_checks = 0;
		n_flt = 0;
		reset_n = 1'b0;
		{bus_write, bus_read, bus_addr, bus_wdata} = 42'h0;
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		t_reset;
		t_conv;
		t_virt;
		t_pm;
		t_model;
		t_count;
		tally_and_finish;
	end

	// About twenty times what the tests need
	initial begin
		#(2000 * 40);
		n_fail = n_fail + 1;
		tally_and_finish;
	end
endmodule // test_spc_access_check
